// ---- rtl/armu_pkg.sv ----
// Constants shared by the address register modify unit.
package armu_pkg;
    // ------------------------------------------------------------
    // Widths and register counts
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int NUM_PTR = 8;
    localparam int NUM_TMP = 4;
    localparam int APB_AW = 8;

    // ------------------------------------------------------------
    // Instruction layout
    // ------------------------------------------------------------
    localparam int OP_LSB = 0;
    localparam int DST_LSB = 4;
    localparam int SRC_LSB = 12;
    localparam int IMM8_LSB = 8;
    localparam int IMM16_LSB = 8;
    localparam int PFX_LSB = 17;
    localparam int LONG_PFX_LSB = 24;
    localparam logic [6:0] SHORT_PREFIX = 7'h0A;
    localparam logic [7:0] LONG_PREFIX = 8'h77;

    // Low three bits of the trailing nibble; the top bit is the slot bit.
    localparam logic [2:0] OP_ADD_REG = 3'h0;
    localparam logic [2:0] OP_MOVE = 3'h1;
    localparam logic [2:0] OP_SUB_REG = 3'h2;
    localparam logic [2:0] OP_ADD_IMM = 3'h4;
    localparam logic [2:0] OP_LOAD_IMM = 3'h5;
    localparam logic [2:0] OP_SUB_IMM = 3'h6;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_LOW_SIZE = 8'h04;
    localparam logic [7:0] ADDR_HIGH_SIZE = 8'h08;
    localparam logic [7:0] ADDR_LOW_START = 8'h0C;
    localparam logic [7:0] ADDR_HIGH_START = 8'h10;
    localparam logic [7:0] ADDR_PTR_BASE = 8'h20;
    localparam logic [7:0] ADDR_TMP_BASE = 8'h40;
    localparam int STAT_LEGACY_BIT = 8;
    localparam logic [15:0] RST_VAL = 16'h0000;
    localparam logic [7:0] RST_CIRC = 8'h00;
endpackage : armu_pkg

// ---- rtl/armu_addr_reg_modify_unit.sv ----
// Address register modify datapath with an APB register window.
`timescale 1ns/1ps

// Function
// - Move copies source register into destination
// - Short load writes 8-bit immediate to register
// - Short immediate is zero extended
// - Long load writes 16-bit constant, 0x77 prefix
// - Register add adds signed source to destination
// - Immediate add adds unsigned 8-bit constant
// - Register subtract removes signed source
// - Immediate subtract removes unsigned 8-bit constant
// - Circular wrap on enabled or qualified pointers
// - Legacy mode always uses low group size
// - Single cycle, never touches data memory
// - Slot bit is ignored; both encodings execute alike
// - Short load nibble 0101 or 1101
// - Repeated issue executes every cycle
// - Register add sign extends the source
// - Immediate subtract nibble 0110 or 1110
module armu_addr_reg_modify_unit #(
    parameter int NUM_PTR = armu_pkg::NUM_PTR,
    parameter int NUM_TMP = armu_pkg::NUM_TMP
) (
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [armu_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction issue from the decode stage
    input wire logic instr_valid,
    input wire logic instr_long,
    input wire logic [31:0] instr_word,
    input wire logic circ_qual,
    // Completion report
    output logic instr_done,
    output logic instr_illegal,
    output logic mem_access
);
    localparam int DW = armu_pkg::DATA_W;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Top bit of a select field: 0 picks a pointer, 1 a temporary.
    function automatic logic sel_is_tmp(input logic [3:0] f);
        sel_is_tmp = f[3];
    endfunction : sel_is_tmp

    // A select is usable only if the register number exists.
    function automatic logic sel_ok(input logic [3:0] f);
        if (f[3]) begin
            sel_ok = (int'(f[2:0]) < NUM_TMP);
        end else begin
            sel_ok = (int'(f[2:0]) < NUM_PTR);
        end
    endfunction : sel_ok

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DW-1:0] ptr_ff [NUM_PTR], nxt_ptr [NUM_PTR];
    logic [DW-1:0] tmp_ff [NUM_TMP], nxt_tmp [NUM_TMP];
    logic [7:0] circ_en_ff, nxt_circ_en;
    logic legacy_ff, nxt_legacy;
    logic [DW-1:0] low_size_ff, nxt_low_size;
    logic [DW-1:0] high_size_ff, nxt_high_size;
    logic [DW-1:0] low_start_ff, nxt_low_start;
    logic [DW-1:0] high_start_ff, nxt_high_start;
    logic done_ff, nxt_done;
    logic illegal_ff, nxt_illegal;
    logic [31:0] prdata_ff, nxt_prdata;
    logic slverr_ff, nxt_slverr;
    logic loaded_ff, nxt_loaded;

    // ------------------------------------------------------------
    // Instruction decode and arithmetic
    // ------------------------------------------------------------
    logic [3:0] src_f;
    logic [3:0] dst_f;
    logic [2:0] op;
    logic legal;
    logic is_arith;
    logic [DW-1:0] src_val;
    logic [DW-1:0] dst_val;
    logic [DW-1:0] imm8_ext;
    logic signed [DW+1:0] delta;
    logic signed [DW+1:0] off;
    logic signed [DW+1:0] size_s;
    logic [DW-1:0] buf_size;
    logic [DW-1:0] buf_start;
    logic use_circ;
    logic [DW-1:0] result;

    // The slot bit (top of the trailing nibble) is accepted either way.
    always_comb begin
        src_f = instr_word[armu_pkg::SRC_LSB +: 4];
        dst_f = instr_word[armu_pkg::DST_LSB +: 4];
        op = instr_word[armu_pkg::OP_LSB +: 3];
        imm8_ext = {8'h00, instr_word[armu_pkg::IMM8_LSB +: 8]};
        legal = 1'b0;
        is_arith = 1'b0;
        if (instr_long) begin
            legal = (instr_word[armu_pkg::LONG_PFX_LSB +: 8] == armu_pkg::LONG_PREFIX);
            op = armu_pkg::OP_LOAD_IMM;
        end else if (instr_word[armu_pkg::PFX_LSB +: 7] == armu_pkg::SHORT_PREFIX) begin
            case (op)
                armu_pkg::OP_MOVE, armu_pkg::OP_ADD_REG, armu_pkg::OP_SUB_REG: begin
                    legal = sel_ok(src_f);
                    is_arith = (op != armu_pkg::OP_MOVE);
                end
                armu_pkg::OP_ADD_IMM, armu_pkg::OP_SUB_IMM: begin
                    legal = 1'b1;
                    is_arith = 1'b1;
                end
                armu_pkg::OP_LOAD_IMM: legal = 1'b1;
                default: legal = 1'b0;
            endcase
        end
        legal = legal && sel_ok(dst_f);
    end

    always_comb begin
        src_val = '0;
        dst_val = '0;
        for (int i = 0; i < NUM_PTR; i++) begin
            if (!sel_is_tmp(src_f) && int'(src_f[2:0]) == i) src_val = ptr_ff[i];
            if (!sel_is_tmp(dst_f) && int'(dst_f[2:0]) == i) dst_val = ptr_ff[i];
        end
        for (int i = 0; i < NUM_TMP; i++) begin
            if (sel_is_tmp(src_f) && int'(src_f[2:0]) == i) src_val = tmp_ff[i];
            if (sel_is_tmp(dst_f) && int'(dst_f[2:0]) == i) dst_val = tmp_ff[i];
        end
    end

    // Signed offset applied by the add and subtract forms.
    always_comb begin
        case (op)
            armu_pkg::OP_ADD_REG: delta = (DW+2)'($signed(src_val));
            armu_pkg::OP_SUB_REG: delta = -(DW+2)'($signed(src_val));
            armu_pkg::OP_ADD_IMM: delta = $signed({2'b00, imm8_ext});
            armu_pkg::OP_SUB_IMM: delta = -$signed({2'b00, imm8_ext});
            default: delta = '0;
        endcase
    end

    // Buffer geometry; legacy mode pins every pointer to the low size.
    always_comb begin
        if (legacy_ff || dst_f[2] == 1'b0) begin
            buf_size = low_size_ff;
        end else begin
            buf_size = high_size_ff;
        end
        buf_start = dst_f[2] ? high_start_ff : low_start_ff;
        use_circ = is_arith && !sel_is_tmp(dst_f) && (buf_size != '0) &&
            (circ_en_ff[dst_f[2:0]] || circ_qual);
    end

    // A single wrap step is enough while each step is smaller than the buffer.
    always_comb begin
        size_s = $signed({2'b00, buf_size});
        off = $signed({2'b00, dst_val}) - $signed({2'b00, buf_start}) + delta;
        if (off >= size_s) begin
            off = off - size_s;
        end else if (off < 0) begin
            off = off + size_s;
        end
        case (op)
            armu_pkg::OP_MOVE: result = src_val;
            armu_pkg::OP_LOAD_IMM: begin
                result = instr_long ? instr_word[armu_pkg::IMM16_LSB +: DW] : imm8_ext;
            end
            default: begin
                if (use_circ) begin
                    result = buf_start + off[DW-1:0];
                end else begin
                    result = dst_val + delta[DW-1:0];
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic apb_wr;
    logic [DW-1:0] wr16;

    // Transfers wait while the unit is frozen and until read data is staged.
    assign pready = penable && ce && loaded_ff;
    assign prdata = prdata_ff;
    assign pslverr = slverr_ff;
    assign apb_wr = psel && pready && pwrite;
    assign wr16 = pwdata[DW-1:0];

    // Read data and error are staged each selected cycle for the next edge.
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b1;
        nxt_loaded = psel && !pready;
        case (paddr)
            armu_pkg::ADDR_STATUS: begin
                nxt_prdata[7:0] = circ_en_ff;
                nxt_prdata[armu_pkg::STAT_LEGACY_BIT] = legacy_ff;
                nxt_slverr = 1'b0;
            end
            armu_pkg::ADDR_LOW_SIZE: {nxt_slverr, nxt_prdata[DW-1:0]} = {1'b0, low_size_ff};
            armu_pkg::ADDR_HIGH_SIZE: {nxt_slverr, nxt_prdata[DW-1:0]} = {1'b0, high_size_ff};
            armu_pkg::ADDR_LOW_START: {nxt_slverr, nxt_prdata[DW-1:0]} = {1'b0, low_start_ff};
            armu_pkg::ADDR_HIGH_START: {nxt_slverr, nxt_prdata[DW-1:0]} = {1'b0, high_start_ff};
            default: begin
                for (int i = 0; i < NUM_PTR; i++) begin
                    if (paddr == 8'(armu_pkg::ADDR_PTR_BASE + 4 * i)) begin
                        nxt_prdata[DW-1:0] = ptr_ff[i];
                        nxt_slverr = 1'b0;
                    end
                end
                for (int i = 0; i < NUM_TMP; i++) begin
                    if (paddr == 8'(armu_pkg::ADDR_TMP_BASE + 4 * i)) begin
                        nxt_prdata[DW-1:0] = tmp_ff[i];
                        nxt_slverr = 1'b0;
                    end
                end
            end
        endcase
        if (!psel) begin
            nxt_slverr = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Next register state
    // ------------------------------------------------------------
    // An instruction write beats an APB write to the same register.
    always_comb begin
        nxt_circ_en = circ_en_ff;
        nxt_legacy = legacy_ff;
        nxt_low_size = low_size_ff;
        nxt_high_size = high_size_ff;
        nxt_low_start = low_start_ff;
        nxt_high_start = high_start_ff;
        nxt_ptr = ptr_ff;
        nxt_tmp = tmp_ff;
        if (apb_wr) begin
            case (paddr)
                armu_pkg::ADDR_STATUS: begin
                    nxt_circ_en = pwdata[7:0];
                    nxt_legacy = pwdata[armu_pkg::STAT_LEGACY_BIT];
                end
                armu_pkg::ADDR_LOW_SIZE: nxt_low_size = wr16;
                armu_pkg::ADDR_HIGH_SIZE: nxt_high_size = wr16;
                armu_pkg::ADDR_LOW_START: nxt_low_start = wr16;
                armu_pkg::ADDR_HIGH_START: nxt_high_start = wr16;
                default: begin
                    for (int i = 0; i < NUM_PTR; i++) begin
                        if (paddr == 8'(armu_pkg::ADDR_PTR_BASE + 4 * i)) nxt_ptr[i] = wr16;
                    end
                    for (int i = 0; i < NUM_TMP; i++) begin
                        if (paddr == 8'(armu_pkg::ADDR_TMP_BASE + 4 * i)) nxt_tmp[i] = wr16;
                    end
                end
            endcase
        end
        if (instr_valid && legal) begin
            for (int i = 0; i < NUM_PTR; i++) begin
                if (!sel_is_tmp(dst_f) && int'(dst_f[2:0]) == i) nxt_ptr[i] = result;
            end
            for (int i = 0; i < NUM_TMP; i++) begin
                if (sel_is_tmp(dst_f) && int'(dst_f[2:0]) == i) nxt_tmp[i] = result;
            end
        end
        nxt_done = instr_valid && legal;
        nxt_illegal = instr_valid && !legal;
    end

    assign mem_access = 1'b0;
    assign instr_done = done_ff;
    assign instr_illegal = illegal_ff;

    // Registers; everything holds while the clock enable is low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_PTR; i++) ptr_ff[i] <= armu_pkg::RST_VAL;
            for (int i = 0; i < NUM_TMP; i++) tmp_ff[i] <= armu_pkg::RST_VAL;
            circ_en_ff <= armu_pkg::RST_CIRC;
            legacy_ff <= 1'b0;
            low_size_ff <= armu_pkg::RST_VAL;
            high_size_ff <= armu_pkg::RST_VAL;
            low_start_ff <= armu_pkg::RST_VAL;
            high_start_ff <= armu_pkg::RST_VAL;
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
            loaded_ff <= 1'b0;
        end else if (ce) begin
            ptr_ff <= nxt_ptr;
            tmp_ff <= nxt_tmp;
            circ_en_ff <= nxt_circ_en;
            legacy_ff <= nxt_legacy;
            low_size_ff <= nxt_low_size;
            high_size_ff <= nxt_high_size;
            low_start_ff <= nxt_low_start;
            high_start_ff <= nxt_high_start;
            done_ff <= nxt_done;
            illegal_ff <= nxt_illegal;
            prdata_ff <= nxt_prdata;
            slverr_ff <= nxt_slverr;
            loaded_ff <= nxt_loaded;
        end
    end
endmodule : armu_addr_reg_modify_unit

// ---- tb/armu_unit_properties.sv ----
// Assertion checker for the address register modify unit.
`timescale 1ns/1ps
module armu_unit_properties #(
    parameter int NUM_PTR = armu_pkg::NUM_PTR,
    parameter int NUM_TMP = armu_pkg::NUM_TMP
) (
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [armu_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Instruction port
    input wire logic instr_valid,
    input wire logic instr_long,
    input wire logic [31:0] instr_word,
    input wire logic circ_qual,
    input wire logic instr_done,
    input wire logic instr_illegal,
    input wire logic mem_access
);
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // Temp selects past the implemented count must be refused, not aliased.
    logic take, dst_ok, src_ok, sh_ok, good, mapped;
    logic [2:0] opc;
    assign take = ce && instr_valid;
    assign opc = instr_word[2:0];
    assign dst_ok = !instr_word[7] || (32'(instr_word[6:4]) < NUM_TMP);
    assign src_ok = !instr_word[15] || (32'(instr_word[14:12]) < NUM_TMP);
    assign sh_ok = instr_word[23:17] == armu_pkg::SHORT_PREFIX && opc != 3'h3
        && opc != 3'h7 && dst_ok && (src_ok || opc[2]);
    assign good = instr_long ? (instr_word[31:24] == armu_pkg::LONG_PREFIX && dst_ok) : sh_ok;
    assign mapped = paddr[1:0] == 2'h0 && (paddr <= armu_pkg::ADDR_HIGH_START
        || (paddr >= armu_pkg::ADDR_PTR_BASE && 32'(paddr) < 32 + 4 * NUM_PTR)
        || (paddr >= armu_pkg::ADDR_TMP_BASE && 32'(paddr) < 64 + 4 * NUM_TMP));

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    // All checks run on the one bus clock and stop while reset is low.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_GOOD_DONE: assert property (take && good |=> instr_done && !instr_illegal)
        else $error("legal instruction without a done pulse");
    AST_BAD_ILLEGAL: assert property (take && !good |=> instr_illegal && !instr_done)
        else $error("undecodable instruction not refused");
    AST_IDLE_QUIET: assert property (!take |=> !instr_done && !instr_illegal)
        else $error("completion pulse without an instruction");
    AST_REPEAT: assert property ((take && good) ##1 (take && good)
        |-> instr_done ##1 instr_done)
        else $error("repeated instruction missed a cycle");
    AST_SLOT_MOVE: assert property (take && !instr_long && sh_ok
        && opc == 3'h1 && instr_word[3] |=> instr_done)
        else $error("move in second slot not executed");
    AST_SLOT_LOAD: assert property (take && !instr_long && sh_ok
        && opc == 3'h5 && instr_word[3] |=> instr_done)
        else $error("short load in second slot not executed");
    AST_NO_MEM: assert property (!mem_access)
        else $error("data memory access raised");
    AST_APB_ZERO_WAIT: assert property ((psel && !penable && ce) ##1 (psel && penable && ce)
        |-> pready)
        else $error("access phase not answered at once");
    AST_READY_QUAL: assert property (pready |-> penable && ce)
        else $error("ready outside an enabled access phase");
    AST_UNMAPPED: assert property (psel && penable && pready |-> pslverr == !mapped)
        else $error("error response does not match the address map");
endmodule : armu_unit_properties

bind armu_addr_reg_modify_unit armu_unit_properties #(.NUM_PTR(NUM_PTR), .NUM_TMP(NUM_TMP))
    armu_unit_properties_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .instr_long(instr_long),
    .instr_word(instr_word), .circ_qual(circ_qual), .instr_done(instr_done),
    .instr_illegal(instr_illegal), .mem_access(mem_access));

// ---- tb/armu_decode_model.sv ----
// Behavioural model of the decode stage that issues instructions.
`timescale 1ns/1ps
module armu_decode_model (
    // Clock
    input wire logic pclk,
    // Instruction issue
    output logic instr_valid,
    output logic instr_long,
    output logic [31:0] instr_word,
    output logic circ_qual
);
    // Idle values at time zero.
    initial begin
        instr_valid = 1'b0;
        instr_long = 1'b0;
        instr_word = 32'h0000_0000;
        circ_qual = 1'b0;
    end

    // Holding valid for reps edges repeats the same instruction.
    // repeated issue
    task automatic issue(input logic lng, input logic [31:0] w, input logic q, input int reps);
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_long <= lng;
        instr_word <= w;
        circ_qual <= q;
        repeat (reps) @(posedge pclk);
        // Released word is inverted so a stale value never looks live.
        instr_valid <= 1'b0;
        instr_word <= ~w;
        circ_qual <= ~q;
    endtask : issue
endmodule : armu_decode_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the address register modify unit.
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic instr_valid, instr_long, circ_qual, instr_done, instr_illegal, mem_access;
    logic [armu_pkg::APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, instr_word;
    int fail_count, num_checks;

    // Free-running 50 MHz clock.
    always #10 pclk = ~pclk;

    armu_addr_reg_modify_unit armu_addr_reg_modify_unit_inst (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_long(instr_long), .instr_word(instr_word),
        .circ_qual(circ_qual), .instr_done(instr_done), .instr_illegal(instr_illegal),
        .mem_access(mem_access));
    armu_decode_model armu_decode_model_inst (.pclk(pclk), .instr_valid(instr_valid),
        .instr_long(instr_long), .instr_word(instr_word), .circ_qual(circ_qual));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // One APB transfer; pready, read data and error are all taken at one rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {16'h0, d}, r, e);
    endtask : wr

    // Register select code to its byte address in the register window.
    function automatic logic [7:0] ra(input logic [3:0] s);
        return (s[3] ? armu_pkg::ADDR_TMP_BASE : armu_pkg::ADDR_PTR_BASE) + {3'h0, s[2:0], 2'h0};
    endfunction : ra

    // Short form: prefix, E bit clear, field, destination, slot and opcode.
    function automatic logic [31:0] sw(input logic [7:0] i, input logic [3:0] d,
                                       input logic [3:0] n);
        return {8'h00, armu_pkg::SHORT_PREFIX, 1'b0, i, d, n};
    endfunction : sw

    // The completion pulse stands in the cycle after the last issue edge.
    task automatic run(input logic lng, input logic [31:0] w, input logic q, input int reps,
                       input logic [3:0] dst, input logic [15:0] exp, input logic ok = 1'b1);
        armu_decode_model_inst.issue(lng, w, q, reps);
        @(posedge pclk);
        chk({30'h0, instr_done, instr_illegal}, {30'h0, ok, !ok});
        rd(ra(dst), {16'h0, exp}, 1'b0);
    endtask : run

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        fail_count = 0;
        num_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(armu_pkg::ADDR_STATUS, 32'h0, 1'b0);
        rd(ra(4'hB), 32'h0, 1'b0);
        rd(8'hFC, 32'h0, 1'b1);
        wr(ra(4'h1), 16'h1234);
        run(1'b0, sw(8'h10, 4'h4, 4'h1), 1'b0, 1, 4'h4, 16'h1234);
        run(1'b0, sw(8'h40, 4'hB, 4'h9), 1'b0, 1, 4'hB, 16'h1234);
        run(1'b0, sw(8'hFF, 4'h0, 4'h5), 1'b0, 1, 4'h0, 16'h00FF);
        run(1'b0, sw(8'hFF, 4'h8, 4'hD), 1'b0, 1, 4'h8, 16'h00FF);
        run(1'b1, {armu_pkg::LONG_PREFIX, 16'hFFFF, 8'h90}, 1'b0, 1, 4'h9, 16'hFFFF);
        wr(ra(4'hA), 16'h8000);
        run(1'b0, sw(8'hA0, 4'h0, 4'h0), 1'b0, 1, 4'h0, 16'h80FF);
        run(1'b0, sw(8'h90, 4'h0, 4'hA), 1'b0, 1, 4'h0, 16'h8100);
        run(1'b0, sw(8'hFF, 4'h0, 4'h4), 1'b0, 1, 4'h0, 16'h81FF);
        run(1'b0, sw(8'hFF, 4'h0, 4'hE), 1'b0, 1, 4'h0, 16'h8100);
        rd(ra(4'hA), 32'h0000_8000, 1'b0);
        wr(armu_pkg::ADDR_LOW_SIZE, 16'h0010);
        wr(armu_pkg::ADDR_LOW_START, 16'h0100);
        wr(armu_pkg::ADDR_HIGH_SIZE, 16'h0008);
        wr(armu_pkg::ADDR_HIGH_START, 16'h0200);
        wr(armu_pkg::ADDR_STATUS, 16'h0004);
        wr(ra(4'h2), 16'h010E);
        wr(ra(4'h3), 16'h010E);
        wr(ra(4'h5), 16'h0201);
        run(1'b0, sw(8'h04, 4'h2, 4'h4), 1'b0, 1, 4'h2, 16'h0102);
        run(1'b0, sw(8'h04, 4'h3, 4'h4), 1'b0, 1, 4'h3, 16'h0112);
        run(1'b0, sw(8'h03, 4'h5, 4'h6), 1'b1, 1, 4'h5, 16'h0206);
        wr(armu_pkg::ADDR_STATUS, 16'h0100);
        rd(armu_pkg::ADDR_STATUS, 32'h0000_0100, 1'b0);
        run(1'b0, sw(8'h04, 4'h5, 4'h4), 1'b1, 1, 4'h5, 16'h020A);
        run(1'b0, sw(8'h01, 4'hB, 4'h4), 1'b0, 3, 4'hB, 16'h1237);
        run(1'b0, sw(8'h55, 4'hC, 4'h5), 1'b0, 1, 4'hB, 16'h1237, 1'b0);
        run(1'b0, 32'h0000_0055, 1'b0, 1, 4'hB, 16'h1237, 1'b0);
        // With the enable low the decode stage offer must be ignored.
        ce <= 1'b0;
        armu_decode_model_inst.issue(1'b0, sw(8'h55, 4'hB, 4'h5), 1'b0, 1);
        ce <= 1'b1;
        rd(ra(4'hB), 32'h0000_1237, 1'b0);
        chk({31'h0, mem_access}, 32'h0);
        wrap_up();
    end

    // Watchdog well beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        wrap_up();
    end
endmodule : tb_top
